// file: logic/aops_busy_gen.sv
// Count change strobe generator: fixed width pulse, update at mid pulse, least gap
`timescale 1ns/1ps
module aops_busy_gen (
    input wire logic clk_in,
    input wire logic rst_in,
    aops_step_if.gen step
);
    typedef struct packed {
        logic busy;
        logic [aops_pkg::BUSY_CNT_W-1:0] cnt;
        logic [aops_pkg::GAP_CNT_W-1:0] gap;
    } aops_gen_type;

    aops_gen_type cur;
    aops_gen_type next_cur;

    always_comb begin
        next_cur = cur;
        if (cur.busy) begin
            if (cur.cnt == aops_pkg::BUSY_LAST) begin
                next_cur.busy = 1'b0;
                next_cur.gap = aops_pkg::GAP_LOAD;
            end else begin
                next_cur.cnt = cur.cnt + 5'h01;
            end
        end else if (cur.gap != 3'h0) begin
            next_cur.gap = cur.gap - 3'h1;
        end else if (step.req) begin
            next_cur.busy = 1'b1;
            next_cur.cnt = 5'h00;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign step.busy = cur.busy;
    assign step.ready = !cur.busy && (cur.gap == 3'h0);
    assign step.update = cur.busy && (cur.cnt == aops_pkg::BUSY_MID);
    assign step.pending = cur.busy && (cur.cnt <= aops_pkg::BUSY_MID);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_pulse_open;
        $rose(cur.busy);
    endsequence
    sequence s_pulse_body;
        ##14 cur.busy ##1 !cur.busy;
    endsequence

    a_busy_pulse_width: assert property (s_pulse_open |-> s_pulse_body)
        else $error("strobe width is not 15 cycles");
    a_busy_gap_least: assert property ($fell(cur.busy) |-> !cur.busy [*6])
        else $error("strobes closer than 150 ns");
    a_update_mid_pulse: assert property (s_pulse_open |-> ##7 step.update)
        else $error("angle update not at strobe midpoint");
endmodule

// file: logic/aops_pkg.sv
// Shared constants and types for the angle output port and self test block
package aops_pkg;
    localparam int ANGLE_W = 16;
    localparam int BYTE_W = 8;
    localparam int LINEAR_W = 14;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
    // Freeze to held data, longest time, rounded down
    localparam int FREEZE_VALID_NS = 300;
    localparam int FREEZE_VALID_CYC = FREEZE_VALID_NS / CLK_PERIOD_NS;
    // Byte enable to valid data and to release, longest times
    localparam int ENABLE_VALID_NS = 150;
    localparam int ENABLE_VALID_CYC = ENABLE_VALID_NS / CLK_PERIOD_NS;
    localparam int ENABLE_RELEASE_NS = 100;
    localparam int ENABLE_RELEASE_CYC = ENABLE_RELEASE_NS / CLK_PERIOD_NS;
    // Count change strobe: 1/(40 x sample rate), nominal width
    localparam int BUSY_PULSE_NS = 375;
    localparam int BUSY_PULSE_CYC = BUSY_PULSE_NS / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W = 5;
    localparam logic [BUSY_CNT_W-1:0] BUSY_LAST = 5'(BUSY_PULSE_CYC - 1);
    localparam logic [BUSY_CNT_W-1:0] BUSY_MID = 5'(BUSY_PULSE_CYC / 2);
    // Least gap between strobes, rounded up
    localparam int BUSY_GAP_NS = 150;
    localparam int BUSY_GAP_CYC = (BUSY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CNT_W = 3;
    localparam logic [GAP_CNT_W-1:0] GAP_LOAD = 3'(BUSY_GAP_CYC);
    // Self test thresholds and filter times
    localparam logic [ANGLE_W-1:0] ERR_LIMIT_LSB = 16'h0064;
    localparam int ERR_DELAY_MS = 500;
    localparam int ERR_DELAY_CYC = ERR_DELAY_MS * CLK_KHZ;
    localparam int LOS_FILTER_MS = 50;
    localparam int LOS_FILTER_CYC = LOS_FILTER_MS * CLK_KHZ;
    localparam int DELAY_CNT_W = 25;
    // Overrange codes in the two top bits, linear mode
    localparam logic [1:0] OVR_NONE = 2'h0;
    localparam logic [1:0] OVR_POS = 2'h1;
    localparam logic [1:0] OVR_NEG = 2'h3;
    localparam logic [LINEAR_W-1:0] LINEAR_MAX = 14'h3FFF;
    localparam logic [BYTE_W-1:0] BYTE_ON = 8'hFF;
    localparam logic [BYTE_W-1:0] BYTE_OFF = 8'h00;

    typedef enum logic [1:0] {
        AOPS_OPEN = 2'b00,
        AOPS_WAIT = 2'b01,
        AOPS_HOLD = 2'b10
    } aops_freeze_type;
endpackage

// file: logic/aops_step_if.sv
// Step request and strobe timing signals between the top and the strobe generator
`timescale 1ns/1ps
interface aops_step_if;
    logic req;
    logic ready;
    logic busy;
    logic pending;
    logic update;

    modport gen (input req, output ready, output busy, output pending, output update);
    modport user (output req, input ready, input busy, input pending, input update);
endinterface

// file: logic/aops_top.sv
// Angle output port: freeze latch, byte enables, count strobe, encoder mode, self test
//
// How it works
// - Linear mode: top two bits show 01 above range, 11 below range.
// - While freeze input is low the output latch holds the angle word steady.
// - Freezing never stops or disturbs the tracking counter.
// - Held data is valid within 300 ns of the freeze input falling.
// - Upper enable drives bits 15..8, lower enable drives bits 7..0, both active low.
// - Bus data is driven within 150 ns of an enable falling.
// - Bus is released within 100 ns of an enable rising.
// - One count strobe is emitted for each one LSB step of the angle.
// - Output data is valid within 50 ns of each strobe midpoint.
// - Each strobe lasts 375 ns.
// - Strobes are at least 150 ns apart.
// - Freeze may come anytime; a running update finishes before the latch closes.
// - Test flag goes low when tracking error exceeds about 100 LSBs.
// - Excess error shows only after 500 ms.
// - Test flag from a large step clears itself once tracking settles.
// - Test flag also goes low on overvelocity or lost null.
// - Loss of signal, both sine and cosine below 800 mV, drives test flag low.
// - Loss of signal detection is filtered over 50 ms.
// - Encoder mode: strobe becomes index at all zeros; bit1 is A, bit1 xor bit0 is B.
// - Encoder mode keeps the low byte driven always.
// - Linear mode output is straight binary, all zeros to all ones.
`timescale 1ns/1ps
module aops_top #(
    parameter int ERR_DELAY_CYC = aops_pkg::ERR_DELAY_CYC,
    parameter int LOS_FILTER_CYC = aops_pkg::LOS_FILTER_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic step_up_in,
    input wire logic step_down_in,
    output logic step_ready_out,
    input wire logic linear_transducer_mode_in,
    input wire logic encoder_mode_in,
    input wire logic angle_freeze_n_in,
    input wire logic upper_byte_enable_n_in,
    input wire logic lower_byte_enable_n_in,
    input wire logic [aops_pkg::ANGLE_W-1:0] tracking_error_in,
    input wire logic overvelocity_in,
    input wire logic null_lost_in,
    input wire logic sin_below_level_in,
    input wire logic cos_below_level_in,
    output logic [aops_pkg::ANGLE_W-1:0] data_out,
    output logic [aops_pkg::ANGLE_W-1:0] data_oe_out,
    output logic count_change_strobe_out,
    output logic test_flag_n_out,
    output logic signal_loss_detect_out
);
    localparam int AW = aops_pkg::ANGLE_W;
    localparam int BW = aops_pkg::BYTE_W;
    localparam int DW = aops_pkg::DELAY_CNT_W;
    localparam logic [DW-1:0] ERR_LAST = DW'(ERR_DELAY_CYC - 1);
    localparam logic [DW-1:0] LOS_LAST = DW'(LOS_FILTER_CYC - 1);
    localparam logic [DW-1:0] CNT_ONE = 25'h0000001;

    typedef struct packed {
        logic [1:0] freeze_sync;
        logic [1:0] upper_sync;
        logic [1:0] lower_sync;
        logic [1:0] enc_sync;
        logic [1:0] sin_sync;
        logic [1:0] cos_sync;
        aops_pkg::aops_freeze_type frz;
        logic [AW-1:0] angle;
        logic [1:0] ovr;
        logic dir;
        logic [AW-1:0] latch;
        logic [AW-1:0] data;
        logic [AW-1:0] oe;
        logic strobe;
        logic [DW-1:0] err_cnt;
        logic err_flag;
        logic [DW-1:0] los_cnt;
        logic los_flag;
        logic test_n;
    } aops_state_type;

    aops_state_type cur;
    aops_state_type next_cur;
    aops_step_if step ();

    logic step_dir;
    logic [AW-1:0] word;
    logic freeze_on;
    logic upper_on;
    logic lower_on;
    logic enc_on;
    logic at_top;
    logic at_bottom;

    aops_busy_gen aops_busy_gen_inst (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .step(step)
    );

    // Step requests come from the tracking loop on this clock; one at a time
    assign step.req = step_up_in ^ step_down_in;
    assign step_dir = step_up_in;
    assign step_ready_out = step.ready;

    assign freeze_on = !cur.freeze_sync[1];
    assign upper_on = !cur.upper_sync[1];
    assign lower_on = !cur.lower_sync[1];
    assign enc_on = cur.enc_sync[1];

    always_comb begin
        at_top = 1'b0;
        at_bottom = 1'b0;
        if (linear_transducer_mode_in) begin
            at_top = cur.angle[aops_pkg::LINEAR_W-1:0] == aops_pkg::LINEAR_MAX;
            at_bottom = cur.angle[aops_pkg::LINEAR_W-1:0] == '0;
        end
    end

    // Word presented to the latch
    always_comb begin
        word = cur.angle;
        if (linear_transducer_mode_in) begin
            word = {cur.ovr, cur.angle[aops_pkg::LINEAR_W-1:0]};
        end
    end

    always_comb begin
        next_cur = cur;
        next_cur.freeze_sync = {cur.freeze_sync[0], angle_freeze_n_in};
        next_cur.upper_sync = {cur.upper_sync[0], upper_byte_enable_n_in};
        next_cur.lower_sync = {cur.lower_sync[0], lower_byte_enable_n_in};
        next_cur.enc_sync = {cur.enc_sync[0], encoder_mode_in};
        next_cur.sin_sync = {cur.sin_sync[0], sin_below_level_in};
        next_cur.cos_sync = {cur.cos_sync[0], cos_below_level_in};

        // Direction is held for the strobe so the midpoint step uses the request taken
        if (step.req && step.ready) begin
            next_cur.dir = step_dir;
        end

        // Tracking counter runs whatever the freeze state
        if (step.update) begin
            if (cur.dir) begin
                if (at_top) begin
                    next_cur.ovr = aops_pkg::OVR_POS;
                end else begin
                    next_cur.angle = cur.angle + 16'h0001;
                    next_cur.ovr = aops_pkg::OVR_NONE;
                end
            end else begin
                if (at_bottom) begin
                    next_cur.ovr = aops_pkg::OVR_NEG;
                end else begin
                    next_cur.angle = cur.angle - 16'h0001;
                    next_cur.ovr = aops_pkg::OVR_NONE;
                end
            end
        end
        if (!linear_transducer_mode_in) begin
            next_cur.ovr = aops_pkg::OVR_NONE;
        end

        // Freeze latch; an update already under way completes first
        case (cur.frz)
            aops_pkg::AOPS_OPEN: begin
                next_cur.latch = word;
                if (freeze_on && step.pending) begin
                    next_cur.frz = aops_pkg::AOPS_WAIT;
                end else if (freeze_on) begin
                    next_cur.frz = aops_pkg::AOPS_HOLD;
                end
            end
            aops_pkg::AOPS_WAIT: begin
                next_cur.latch = word;
                if (!freeze_on) begin
                    next_cur.frz = aops_pkg::AOPS_OPEN;
                end else if (!step.pending) begin
                    next_cur.frz = aops_pkg::AOPS_HOLD;
                end
            end
            aops_pkg::AOPS_HOLD: begin
                if (!freeze_on) begin
                    next_cur.frz = aops_pkg::AOPS_OPEN;
                end
            end
            default: begin
                next_cur.frz = aops_pkg::AOPS_OPEN;
            end
        endcase

        // Bus bytes and their drive enables
        next_cur.data = cur.latch;
        next_cur.oe = {upper_on ? aops_pkg::BYTE_ON : aops_pkg::BYTE_OFF,
                       lower_on ? aops_pkg::BYTE_ON : aops_pkg::BYTE_OFF};
        next_cur.strobe = step.busy;
        if (enc_on) begin
            next_cur.data[0] = cur.latch[1] ^ cur.latch[0];
            next_cur.oe[BW-1:0] = aops_pkg::BYTE_ON;
            next_cur.strobe = cur.latch == '0;
        end

        // Excess tracking error, shown only after the settle delay
        if (tracking_error_in > aops_pkg::ERR_LIMIT_LSB) begin
            if (cur.err_cnt == ERR_LAST) begin
                next_cur.err_flag = 1'b1;
            end else begin
                next_cur.err_cnt = cur.err_cnt + CNT_ONE;
            end
        end else begin
            next_cur.err_cnt = '0;
            next_cur.err_flag = 1'b0;
        end

        // Loss of signal, filtered against reference ripple
        if (cur.sin_sync[1] && cur.cos_sync[1]) begin
            if (cur.los_cnt == LOS_LAST) begin
                next_cur.los_flag = 1'b1;
            end else begin
                next_cur.los_cnt = cur.los_cnt + CNT_ONE;
            end
        end else begin
            next_cur.los_cnt = '0;
            next_cur.los_flag = 1'b0;
        end

        next_cur.test_n = !(cur.err_flag || cur.los_flag
                            || overvelocity_in || null_lost_in);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur <= '0;
            cur.freeze_sync <= 2'h3;
            cur.upper_sync <= 2'h3;
            cur.lower_sync <= 2'h3;
            cur.frz <= aops_pkg::AOPS_OPEN;
            cur.test_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign data_out = cur.data;
    assign data_oe_out = cur.oe;
    assign count_change_strobe_out = cur.strobe;
    assign test_flag_n_out = cur.test_n;
    assign signal_loss_detect_out = cur.los_flag;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_freeze_fall;
        $fell(cur.freeze_sync[1]);
    endsequence
    sequence s_held;
        cur.frz == aops_pkg::AOPS_HOLD;
    endsequence

    a_freeze_holds_latch: assert property (s_held ##1 s_held |-> $stable(cur.latch))
        else $error("latch moved while frozen");
    a_counter_keeps_tracking: assert property (
        cur.frz == aops_pkg::AOPS_HOLD && step.update && cur.dir && !at_top
        |=> cur.angle == $past(cur.angle) + 16'h0001)
        else $error("tracking counter stalled by freeze");
    a_freeze_latency: assert property (s_freeze_fall |-> ##[1:9] s_held)
        else $error("held data later than 300 ns");
    a_upper_drive: assert property ($fell(cur.upper_sync[1]) |=> cur.oe[AW-1:BW] == 8'hFF)
        else $error("upper byte not driven after enable");
    a_upper_release: assert property ($rose(cur.upper_sync[1]) |=> cur.oe[AW-1:BW] == 8'h00)
        else $error("upper byte not released after enable");
    a_lower_follows: assert property (!enc_on && $rose(cur.lower_sync[1]) |=> cur.oe[BW-1:0] == 8'h00)
        else $error("lower byte not released after enable");
    a_encoder_low_on: assert property (cur.enc_sync[1] |=> cur.oe[BW-1:0] == 8'hFF)
        else $error("low byte not driven in encoder mode");
    a_data_after_mid: assert property (
        cur.frz == aops_pkg::AOPS_OPEN && !freeze_on && !linear_transducer_mode_in && !enc_on
        && step.update ##1 cur.frz == aops_pkg::AOPS_OPEN && !linear_transducer_mode_in
        ##1 !enc_on |=> cur.data == $past(cur.angle, 2))
        else $error("output not updated after strobe midpoint");
    a_overrange_code: assert property (
        linear_transducer_mode_in && step.update && cur.dir && at_top |=> cur.ovr == 2'h1)
        else $error("positive overrange code missing");
    a_error_delay: assert property ($rose(cur.err_flag) |-> $past(cur.err_cnt) == ERR_LAST)
        else $error("excess error shown before delay");
    a_test_flag_low: assert property (
        cur.err_flag || cur.los_flag || overvelocity_in || null_lost_in |=> !cur.test_n)
        else $error("test flag not low on fault");
    a_loss_filter: assert property (!cur.sin_sync[1] |=> !cur.los_flag)
        else $error("loss of signal without both inputs low");
    a_overrange_neg: assert property (
        linear_transducer_mode_in && step.update && !cur.dir && at_bottom
        |=> cur.ovr == aops_pkg::OVR_NEG)
        else $error("negative overrange code missing");
    a_freeze_waits: assert property (
        cur.frz == aops_pkg::AOPS_OPEN && freeze_on && step.pending
        |=> cur.frz == aops_pkg::AOPS_WAIT)
        else $error("freeze closed during a running update");
    a_lower_drive: assert property ($fell(cur.lower_sync[1]) |=> cur.oe[BW-1:0] == 8'hFF)
        else $error("lower byte not driven after enable");
    a_strobe_follows: assert property (!enc_on |=> cur.strobe == $past(step.busy))
        else $error("count strobe does not follow the step pulse");
    a_index_marker: assert property (enc_on |=> cur.strobe == ($past(cur.latch) == '0))
        else $error("index marker wrong in encoder mode");
endmodule

// file: tb/aops_host_model.sv
// Host model: drives freeze and byte enables and reads the 16-bit angle bus
`timescale 1ns/1ps
module aops_host_model (
    input wire logic clk_in,
    input wire logic freeze_req_in,
    input wire logic [1:0] byte_req_in,
    input wire logic [15:0] data_in,
    input wire logic [15:0] data_oe_in,
    output logic angle_freeze_n_out,
    output logic upper_byte_enable_n_out,
    output logic lower_byte_enable_n_out,
    output logic [15:0] bus_word_out
);
    logic [2:0] req_q = 3'h0;
    logic [15:0] last = 16'h0000;
    // Pins move just after the edge; freeze is applied with no regard to the strobe
    always @(posedge clk_in) begin
        req_q <= {freeze_req_in, byte_req_in};
        last <= data_in;
    end
    assign angle_freeze_n_out = ~req_q[2];
    assign upper_byte_enable_n_out = ~req_q[1];
    assign lower_byte_enable_n_out = ~req_q[0];
    // Released bits float: show the inverse of the last word, never a stale copy
    assign bus_word_out = (data_in & data_oe_in) | (~last & ~data_oe_in);
endmodule

// file: tb/aops_top_bench.sv
// Self-checking bench for the angle output port and self test block
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin n_compared++; if ((act) !== (exp)) begin \
    err_count++; $display("mismatch %0t %s", $time, msg); end end
module aops_top_bench;
    localparam int ERR_CYC = 20;
    localparam int LOS_CYC = 10;
    localparam int WATCH_CYC = 20000;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic step_up = 1'b0, step_down = 1'b0, linear = 1'b0, encoder = 1'b0;
    logic freeze_req = 1'b0, overvel = 1'b0, null_lost = 1'b0, sin_low = 1'b0, cos_low = 1'b0;
    logic [1:0] byte_req = 2'h0;
    logic [15:0] terr = 16'h0000;
    logic step_ready, strobe, test_flag_n, signal_loss_detect, freeze_n, upper_n, lower_n;
    logic [15:0] data, oe, bus_word, mask;
    logic [15:0] angle = 16'h0000, held = 16'h0000;
    logic frozen = 1'b0, watch = 1'b1;
    logic [15:0] expq[$];
    logic [31:0] seed = 32'h00013B2C;
    int err_count = 0, n_compared = 0, hi = 0, lo = 99;

    always #12.5 clk_in = ~clk_in;

    aops_top #(.ERR_DELAY_CYC(ERR_CYC), .LOS_FILTER_CYC(LOS_CYC)) aops_top_inst (
        .clk_in(clk_in), .rst_in(rst_in), .step_up_in(step_up), .step_down_in(step_down),
        .step_ready_out(step_ready), .linear_transducer_mode_in(linear),
        .encoder_mode_in(encoder), .angle_freeze_n_in(freeze_n),
        .upper_byte_enable_n_in(upper_n), .lower_byte_enable_n_in(lower_n),
        .tracking_error_in(terr), .overvelocity_in(overvel), .null_lost_in(null_lost),
        .sin_below_level_in(sin_low), .cos_below_level_in(cos_low), .data_out(data),
        .data_oe_out(oe), .count_change_strobe_out(strobe), .test_flag_n_out(test_flag_n),
        .signal_loss_detect_out(signal_loss_detect));

    aops_host_model aops_host_model_inst (
        .clk_in(clk_in), .freeze_req_in(freeze_req), .byte_req_in(byte_req),
        .data_in(data), .data_oe_in(oe), .angle_freeze_n_out(freeze_n),
        .upper_byte_enable_n_out(upper_n), .lower_byte_enable_n_out(lower_n),
        .bus_word_out(bus_word));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic settle;
        int n;
        n = 0;
        @(posedge clk_in);
        while ((step_ready !== 1'b1 || (strobe !== 1'b0 && !encoder)) && n < 64) begin
            @(posedge clk_in);
            n++;
        end
        `CHK(n < 64, 1'b1, "strobe did not settle")
    endtask

    // One step request, held until the edge that takes it; notes the expected word
    task automatic do_step(input logic up);
        int n;
        n = 0;
        @(posedge clk_in);
        while (step_ready !== 1'b1 && n < 64) begin
            @(posedge clk_in);
            n++;
        end
        `CHK(n < 64, 1'b1, "step not accepted")
        step_up <= up;
        step_down <= ~up;
        @(posedge clk_in);
        step_up <= 1'b0;
        step_down <= 1'b0;
        angle = up ? angle + 16'h0001 : angle - 16'h0001;
        if (watch) expq.push_back(frozen ? held : angle);
    endtask

    // Watches the strobe: width, gap, and the word shortly after mid pulse
    always @(posedge clk_in) begin
        if (!watch || rst_in) begin
            hi = 0;
            lo = 99;
        end else if (strobe === 1'b1) begin
            if (hi == 0) `CHK(lo >= aops_pkg::BUSY_GAP_CYC, 1'b1, "strobe gap")
            hi++;
            if (hi == 10) begin
                if (expq.size() == 0) `CHK(1'b0, 1'b1, "strobe without step")
                else `CHK(data, expq.pop_front(), "word after strobe")
            end
        end else begin
            if (hi != 0) begin
                `CHK(hi == aops_pkg::BUSY_PULSE_CYC, 1'b1, "strobe width")
                lo = 0;
            end
            hi = 0;
            lo++;
        end
    end

    initial begin
        repeat (WATCH_CYC) @(posedge clk_in);
        err_count++;
        $display("mismatch %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        `CHK({data, oe, strobe, test_flag_n, signal_loss_detect}, {32'h0, 3'b010}, "reset values")
        `CHK(step_ready, 1'b1, "ready after reset")
        seed = xs(seed);
        repeat (3 + seed[2:0]) do_step(1'b1);
        do_step(1'b0);
        settle();
        $display("test steps done");
        freeze_req <= 1'b1;
        repeat (13) @(posedge clk_in);
        held = angle;
        frozen = 1'b1;
        `CHK(data, angle, "held after freeze")
        repeat (3) do_step(1'b1);
        settle();
        `CHK(data, held, "held while counting")
        freeze_req <= 1'b0;
        frozen = 1'b0;
        repeat (8) @(posedge clk_in);
        `CHK(data, angle, "counter kept tracking")
        do_step(1'b1);
        repeat (3) @(posedge clk_in);
        freeze_req <= 1'b1;
        settle();
        `CHK(data, angle, "freeze waits for update")
        held = angle;
        frozen = 1'b1;
        do_step(1'b1);
        settle();
        `CHK(data, held, "held after late freeze")
        freeze_req <= 1'b0;
        frozen = 1'b0;
        repeat (8) @(posedge clk_in);
        $display("test freeze done");
        for (int k = 1; k < 4; k++) begin
            byte_req <= k[1:0];
            mask = {{8{k[1]}}, {8{k[0]}}};
            repeat (7) @(posedge clk_in);
            `CHK(oe, mask, "enable drive")
            `CHK(bus_word & mask, angle & mask, "bus bytes")
            byte_req <= 2'h0;
            repeat (5) @(posedge clk_in);
            `CHK(oe, 16'h0000, "enable release")
        end
        $display("test enables done");
        watch = 1'b0;
        linear <= 1'b1;
        while (angle != 16'h0000) do_step(1'b0);
        settle();
        `CHK(data, 16'h0000, "linear bottom")
        do_step(1'b0);
        settle();
        angle = 16'h0000;
        `CHK(data, 16'hC000, "negative overrange")
        do_step(1'b1);
        settle();
        `CHK(data, 16'h0001, "overrange cleared")
        linear <= 1'b0;
        $display("test linear done");
        seed = xs(seed);
        terr <= 16'h0065 + {8'h00, seed[7:0]};
        repeat (15) @(posedge clk_in);
        `CHK(test_flag_n, 1'b1, "error delay")
        repeat (20) @(posedge clk_in);
        `CHK(test_flag_n, 1'b0, "excess error")
        terr <= 16'h0064;
        repeat (40) @(posedge clk_in);
        `CHK(test_flag_n, 1'b1, "error at limit")
        overvel <= 1'b1;
        repeat (3) @(posedge clk_in);
        `CHK(test_flag_n, 1'b0, "overvelocity")
        overvel <= 1'b0;
        null_lost <= 1'b1;
        repeat (3) @(posedge clk_in);
        `CHK(test_flag_n, 1'b0, "null lost")
        null_lost <= 1'b0;
        sin_low <= 1'b1;
        cos_low <= 1'b1;
        repeat (6) @(posedge clk_in);
        `CHK(signal_loss_detect, 1'b0, "loss filtered")
        repeat (14) @(posedge clk_in);
        `CHK({signal_loss_detect, test_flag_n}, 2'b10, "loss of signal")
        cos_low <= 1'b0;
        repeat (5) @(posedge clk_in);
        `CHK({signal_loss_detect, test_flag_n}, 2'b01, "one input low")
        sin_low <= 1'b0;
        $display("test self test done");
        encoder <= 1'b1;
        repeat (6) @(posedge clk_in);
        for (int k = 0; k < 3; k++) begin
            do_step(k == 0);
            settle();
            `CHK(oe[7:0], 8'hFF, "low byte driven")
            `CHK(data[1:0], {angle[1], angle[1] ^ angle[0]}, "quadrature")
            `CHK(strobe, angle == 16'h0000, "index")
        end
        $display("test encoder done");
        `CHK(expq.size() == 0, 1'b1, "steps without strobe")
        stop_test();
    end
endmodule
